// >>> bbae_pkg.sv
// Purpose: shared constants and types for the byte/bit ALU instruction executor
// Assumes: 14-bit instruction words, 7-bit file addresses, 8-bit data
// Notes: APB register map for software control and status
//
// Behaviour
// - Read-modify-write of an I/O port uses pin values, not output latch.
// - Writing the timer count register clears prescaler when assigned to timer zero.
// - Program counter change or true test takes two cycles, second a no-operation.
// - Add immediate adds 8-bit literal to accumulator, updates carry, digit carry, zero.
// - Bit clear forces bit b of file f to zero, no flags.
// - Add file sums accumulator and f; destination bit picks accumulator or f.
// - Bit set forces bit b of file f to one, no flags.
// - AND immediate masks accumulator with literal, updates only zero.
// - Test bit skip when zero discards next instruction when bit is zero.
// - AND file masks accumulator with f to chosen destination, only zero.
// - Instruction 14 bits; byte ops: 6-bit opcode, destination, 7-bit address.
package bbae_pkg;
    localparam int INSN_W = 14;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    // Byte op opcodes, bits 13:8
    localparam logic [5:0] OP_ADD_FILE = 6'h07;
    localparam logic [5:0] OP_AND_FILE = 6'h05;
    // Bit op prefix bits 13:12 and sub-op bits 11:10
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] BIT_CLR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_TSTZ = 2'h2;
    // Literal ops: add immediate bits 13:9, AND immediate bits 13:8
    localparam logic [4:0] OP_ADD_IMM = 5'h1F;
    localparam logic [5:0] OP_AND_IMM = 6'h39;
    localparam int DEST_BIT = 7;
    // Status bit positions
    localparam int ST_C = 0;
    localparam int ST_DIG_C = 1;
    localparam int ST_Z = 2;
    // Special file addresses
    localparam logic [6:0] ADDR_TIMER = 7'h01;
    localparam logic [6:0] ADDR_PORT0 = 7'h05;
    // APB map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_INSN = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_PRESC = 8'h10;
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam int CTRL_PRESC_TIMER = 0;

    typedef struct packed {
        logic [DATA_W-1:0] res;
        logic c;
        logic dig_c;
        logic z;
        logic wr_acc;
        logic wr_file;
        logic upd_c;
        logic upd_z;
        logic skip;
        logic legal;
    } bbae_alu_out_type;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bbae_file_wr_type;
endpackage : bbae_pkg

// >>> bbae_alu.sv
// Purpose: combinational decode and arithmetic for supported instructions
// Assumes: file operand already selected (pins for I/O port)
// Notes: unsupported words report legal low
`timescale 1ns/1ns
module bbae_alu import bbae_pkg::*; (
    input wire logic [INSN_W-1:0] i_insn,
    input wire logic [DATA_W-1:0] i_acc,
    input wire logic [DATA_W-1:0] i_fval,
    output bbae_alu_out_type o_out
);
    logic [DATA_W-1:0] opnd;
    logic [DATA_W:0] sum;
    logic [4:0] lsum;
    logic [DATA_W-1:0] bmask;
    logic is_imm;

    always_comb begin
        is_imm = (i_insn[13:9] == OP_ADD_IMM) || (i_insn[13:8] == OP_AND_IMM);
        opnd = is_imm ? i_insn[7:0] : i_fval;
        sum = {1'b0, i_acc} + {1'b0, opnd};
        lsum = {1'b0, i_acc[3:0]} + {1'b0, opnd[3:0]};
        bmask = 8'h01 << i_insn[9:7];
        o_out = '0;
        o_out.c = sum[DATA_W];
        o_out.dig_c = lsum[4];
        if (i_insn[13:9] == OP_ADD_IMM) begin
            o_out.res = sum[DATA_W-1:0];
            o_out.wr_acc = 1'b1;
            o_out.upd_c = 1'b1;
            o_out.upd_z = 1'b1;
            o_out.legal = 1'b1;
        end else if (i_insn[13:8] == OP_AND_IMM) begin
            o_out.res = i_acc & opnd;
            o_out.wr_acc = 1'b1;
            o_out.upd_z = 1'b1;
            o_out.legal = 1'b1;
        end else if (i_insn[13:8] == OP_ADD_FILE || i_insn[13:8] == OP_AND_FILE) begin
            o_out.res = (i_insn[13:8] == OP_ADD_FILE) ? sum[DATA_W-1:0] : (i_acc & opnd);
            o_out.wr_acc = ~i_insn[DEST_BIT];
            o_out.wr_file = i_insn[DEST_BIT];
            o_out.upd_c = (i_insn[13:8] == OP_ADD_FILE);
            o_out.upd_z = 1'b1;
            o_out.legal = 1'b1;
        end else if (i_insn[13:12] == GRP_BIT) begin
            unique case (i_insn[11:10])
                BIT_CLR: begin
                    o_out.res = opnd & ~bmask;
                    o_out.wr_file = 1'b1;
                    o_out.legal = 1'b1;
                end
                BIT_SET: begin
                    o_out.res = opnd | bmask;
                    o_out.wr_file = 1'b1;
                    o_out.legal = 1'b1;
                end
                BIT_TSTZ: begin
                    o_out.skip = ~|(opnd & bmask);
                    o_out.legal = 1'b1;
                end
                default: o_out.legal = 1'b0;
            endcase
        end
        o_out.z = (o_out.res == 8'h00);
    end
endmodule : bbae_alu

// >>> bbae_regfile.sv
// Purpose: 128-byte data file register memory
// Assumes: single write port, asynchronous read
// Notes: timer and port locations are served outside
`timescale 1ns/1ns
module bbae_regfile import bbae_pkg::*; (
    input wire logic i_clk,
    input wire bbae_file_wr_type i_wr,
    input wire logic [ADDR_W-1:0] i_raddr,
    output logic [DATA_W-1:0] o_rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge i_clk) begin
        if (i_wr.we) begin
            mem[i_wr.addr] <= i_wr.wdata;
        end
    end

    assign o_rdata = mem[i_raddr];
endmodule : bbae_regfile

// >>> bbae_exec.sv
// Purpose: executes supported byte and bit instructions, APB-controlled
// Assumes: software writes one instruction word per REG_INSN write
// Notes: a taken skip inserts a no-operation cycle; an unsupported word changes nothing
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
module bbae_exec import bbae_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [DATA_W-1:0] i_port_pins,
    output logic [DATA_W-1:0] o_port_latch,
    output logic [DATA_W-1:0] o_timer_count,
    output logic o_presc_clear,
    output logic o_busy
);
    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_NOP} bbae_state_type;

    bbae_state_type state_r;
    logic [INSN_W-1:0] insn_r;
    logic [DATA_W-1:0] acc_r;
    logic [2:0] status_r;
    logic [31:0] ctrl_r;
    logic [DATA_W-1:0] port_latch_r;
    logic [DATA_W-1:0] tmr_r;
    logic presc_clr_r;
    logic [15:0] presc_clr_cnt_r;
    logic skip_pend_r;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] fval;
    logic [ADDR_W-1:0] faddr;
    bbae_alu_out_type alu;
    bbae_file_wr_type fwr;
    logic apb_wr;
    logic insn_wr;
    logic exec_now;
    logic commit;
    logic skip_take;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
        addr_hit = (a == r);
    endfunction : addr_hit

    assign faddr = insn_r[ADDR_W-1:0];
    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign insn_wr = apb_wr && addr_hit(i_paddr, REG_INSN);
    assign exec_now = (state_r == S_EXEC);
    // Discarded word after a taken skip changes nothing
    assign commit = exec_now && alu.legal && !skip_pend_r;
    assign skip_take = commit && alu.skip;

    always_comb begin
        if (faddr == ADDR_PORT0) begin
            fval = i_port_pins;
        end else if (faddr == ADDR_TIMER) begin
            fval = tmr_r;
        end else begin
            fval = mem_rdata;
        end
    end

    bbae_alu u_alu (
        .i_insn(insn_r),
        .i_acc(acc_r),
        .i_fval(fval),
        .o_out(alu)
    );

    always_comb begin
        fwr.we = commit && alu.wr_file
            && faddr != ADDR_PORT0 && faddr != ADDR_TIMER;
        fwr.addr = faddr;
        fwr.wdata = alu.res;
    end

    bbae_regfile u_regfile (
        .i_clk(i_clk),
        .i_wr(fwr),
        .i_raddr(faddr),
        .o_rdata(mem_rdata)
    );

    // Sequencer: a taken skip adds a second, idle cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= S_IDLE;
            insn_r <= '0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (insn_wr) begin
                        insn_r <= i_pwdata[INSN_W-1:0];
                        state_r <= S_EXEC;
                    end
                end
                S_EXEC: state_r <= skip_take ? S_NOP : S_IDLE;
                S_NOP: state_r <= S_IDLE;
            endcase
        end
    end

    // Skipped word: next instruction is discarded
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            skip_pend_r <= 1'b0;
        end else if (exec_now) begin
            skip_pend_r <= skip_take;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            acc_r <= '0;
            status_r <= '0;
        end else begin
            if (apb_wr && addr_hit(i_paddr, REG_ACC)) begin
                acc_r <= i_pwdata[DATA_W-1:0];
            end
            if (apb_wr && addr_hit(i_paddr, REG_STATUS)) begin
                status_r <= i_pwdata[2:0];
            end
            // Execution results win over a same-cycle software write
            if (commit) begin
                if (alu.wr_acc) begin
                    acc_r <= alu.res;
                end
                if (alu.upd_c) begin
                    status_r[ST_C] <= alu.c;
                    status_r[ST_DIG_C] <= alu.dig_c;
                end
                if (alu.upd_z) begin
                    status_r[ST_Z] <= alu.z;
                end
            end
        end
    end

    // Port latch and timer count targets of file writes
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            port_latch_r <= '0;
            tmr_r <= '0;
        end else if (commit && alu.wr_file) begin
            if (faddr == ADDR_PORT0) begin
                port_latch_r <= alu.res;
            end
            if (faddr == ADDR_TIMER) begin
                tmr_r <= alu.res;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            presc_clr_r <= 1'b0;
            presc_clr_cnt_r <= '0;
        end else begin
            presc_clr_r <= commit && alu.wr_file
                && faddr == ADDR_TIMER && ctrl_r[CTRL_PRESC_TIMER];
            if (presc_clr_r) begin
                presc_clr_cnt_r <= presc_clr_cnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_r <= RST_CTRL;
        end else if (apb_wr && addr_hit(i_paddr, REG_CTRL)) begin
            ctrl_r <= {31'h0, i_pwdata[CTRL_PRESC_TIMER]};
        end
    end

    always_comb begin
        o_prdata = 32'h0000_0000;
        o_pslverr = 1'b0;
        if (i_psel && i_penable) begin
            if (addr_hit(i_paddr, REG_CTRL)) begin
                o_prdata = ctrl_r;
            end else if (addr_hit(i_paddr, REG_INSN)) begin
                o_prdata = {17'h0, skip_pend_r, insn_r};
            end else if (addr_hit(i_paddr, REG_ACC)) begin
                o_prdata = {24'h0, acc_r};
            end else if (addr_hit(i_paddr, REG_STATUS)) begin
                o_prdata = {29'h0, status_r};
            end else if (addr_hit(i_paddr, REG_PRESC)) begin
                o_prdata = {16'h0, presc_clr_cnt_r};
            end else begin
                o_pslverr = 1'b1;
            end
        end
    end

    // Instruction writes stall until the executor is idle
    assign o_pready = !(insn_wr && state_r != S_IDLE);
    assign o_port_latch = port_latch_r;
    assign o_timer_count = tmr_r;
    assign o_presc_clear = presc_clr_r;
    assign o_busy = (state_r != S_IDLE);
endmodule : bbae_exec

// >>> bbae_monitor.sv
// Purpose: port checker for the executor
// Assumes: one clock, synchronous active-low reset
// Notes: bound below to every executor
`timescale 1ns/1ns
module bbae_monitor import bbae_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [DATA_W-1:0] o_port_latch,
    input wire logic [DATA_W-1:0] o_timer_count,
    input wire logic o_presc_clear,
    input wire logic o_busy
);
    wire acc_ph = i_psel && i_penable;
    wire insn_wr = acc_ph && i_pwrite && i_paddr == REG_INSN;
    wire mapped = i_paddr inside {REG_CTRL, REG_INSN, REG_ACC, REG_STATUS, REG_PRESC};
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    AST_NO_WAIT: assert property (acc_ph && !insn_wr |-> o_pready)
        else $error("unexpected wait state");
    AST_UNMAPPED: assert property (acc_ph && !mapped |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_STALL: assert property (insn_wr && o_busy |-> !o_pready)
        else $error("instruction taken while busy");
    AST_BUSY_SPAN: assert property ($rose(o_busy) |-> ##[1:2] !o_busy)
        else $error("execution over two cycles");
    AST_PRESC_PULSE: assert property (o_presc_clear |=> !o_presc_clear)
        else $error("prescaler clear too long");
    AST_PRESC_CAUSE: assert property (o_presc_clear |-> $past(o_busy) || $past(o_busy, 2))
        else $error("prescaler clear without instruction");
    AST_TIMER_SRC: assert property ($changed(o_timer_count) |-> $past(o_busy))
        else $error("timer changed while idle");
    AST_LATCH_SRC: assert property ($changed(o_port_latch) |-> $past(o_busy))
        else $error("port latch changed while idle");
endmodule : bbae_monitor

bind bbae_exec bbae_monitor u_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_port_latch(o_port_latch),
    .o_timer_count(o_timer_count), .o_presc_clear(o_presc_clear), .o_busy(o_busy));

// >>> bbae_pin_model.sv
// Purpose: external levels on the I/O port pins
// Assumes: pins are inputs driven from outside
// Notes: released pins show the inverse level
`timescale 1ns/1ns
module bbae_pin_model import bbae_pkg::*; (
    input wire logic i_drive,
    input wire logic [DATA_W-1:0] i_level,
    output logic [DATA_W-1:0] o_pins
);
    assign o_pins = i_drive ? i_level : ~i_level;
endmodule : bbae_pin_model

// >>> byte_bit_alu_instruction_exec_tb.sv
// Purpose: self-checking bench for the executor
// Assumes: APB driven at rising edges
// Notes: file cells seeded by AND then ADD to file
`timescale 1ns/1ns
module byte_bit_alu_instruction_exec_tb import bbae_pkg::*;;
    typedef struct packed {
        logic [13:0] insn;
        logic [7:0] acc;
        logic [7:0] st;
        logic [7:0] acc_x;
        logic [7:0] st_x;
    } bbae_row_type;
    bbae_row_type rows [6] = '{
        '{14'h3E01, 8'hFF, 8'h00, 8'h00, 8'h07},
        '{14'h3E08, 8'h08, 8'h00, 8'h10, 8'h02},
        '{14'h3F80, 8'h80, 8'h02, 8'h00, 8'h05},
        '{14'h3E00, 8'h12, 8'h07, 8'h12, 8'h00},
        '{14'h39F0, 8'h0F, 8'h03, 8'h00, 8'h07},
        '{14'h39FF, 8'hA5, 8'h07, 8'hA5, 8'h03}
    };
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, busy, pclr, err_s;
    logic [7:0] pins, latch, tcount;
    logic [7:0] lvl = 8'hF0;
    int miscompares = 0;
    int n_compared = 0;
    always #25 clk = ~clk;
    bbae_pin_model u_pins (.i_drive(1'b1), .i_level(lvl), .o_pins(pins));
    bbae_exec dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_port_pins(pins), .o_port_latch(latch),
        .o_timer_count(tcount), .o_presc_clear(pclr), .o_busy(busy));
    task automatic complete_run;
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic keep);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err_s = pslverr;
        penable <= 1'b0;
        if (!keep) begin
            psel <= 1'b0;
        end
        if (pready !== 1'b1) begin
            check("pready", 1'b0, 1'b1);
            complete_run;
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 1'b0);
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        apb(1'b0, a, 32'h0, 1'b0);
        check(nm, q, {24'h0, exp});
        @(posedge clk);
    endtask : rd
    // Counts busy cycles after the instruction write is taken
    task automatic ex(input logic [13:0] insn, input int cyc_x);
        int cyc;
        cyc = 0;
        apb(1'b1, REG_INSN, {18'h0, insn}, 1'b0);
        do begin
            @(posedge clk);
            if (busy === 1'b1) begin
                cyc++;
            end
        end while (busy === 1'b1 && cyc < 8);
        check("busy cycles", cyc, cyc_x);
    endtask : ex
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("outputs", {busy, pclr, latch, tcount}, 32'h0);
        rd(REG_CTRL, 8'h00, "ctrl");
        rd(REG_ACC, 8'h00, "acc");
        rd(REG_STATUS, 8'h00, "status");
        rd(REG_PRESC, 8'h00, "clears");
        rd(8'h14, 8'h00, "unmapped");
        check("slverr", err_s, 1'b1);
        foreach (rows[i]) begin
            wr(REG_ACC, rows[i].acc);
            wr(REG_STATUS, rows[i].st);
            ex(rows[i].insn, 1);
            rd(REG_ACC, rows[i].acc_x, "acc");
            rd(REG_STATUS, rows[i].st_x, "status");
        end
        wr(REG_ACC, 8'h00);
        ex(14'h05A0, 1);
        wr(REG_ACC, 8'h5A);
        ex(14'h07A0, 1);
        rd(REG_ACC, 8'h5A, "acc kept");
        ex(14'h0720, 1);
        rd(REG_ACC, 8'hB4, "acc sum");
        rd(REG_STATUS, 8'h02, "sum flags");
        wr(REG_STATUS, 8'h05);
        ex(14'h17A0, 1);
        ex(14'h10A0, 1);
        rd(REG_STATUS, 8'h05, "bit flags");
        wr(REG_ACC, 8'h00);
        ex(14'h0720, 1);
        rd(REG_ACC, 8'hD8, "file bits");
        wr(REG_ACC, 8'h0F);
        wr(REG_STATUS, 8'h03);
        ex(14'h0520, 1);
        rd(REG_ACC, 8'h08, "and file");
        rd(REG_STATUS, 8'h03, "and flags");
        wr(REG_ACC, 8'h00);
        ex(14'h1820, 2);
        ex(14'h3E01, 1);
        rd(REG_ACC, 8'h00, "skipped");
        apb(1'b1, REG_INSN, 32'h1820, 1'b1);
        ex(14'h3E05, 1);
        apb(1'b1, REG_INSN, 32'h19A0, 1'b1);
        ex(14'h3E01, 1);
        rd(REG_ACC, 8'h01, "not skipped");
        ex(14'h1405, 1);
        check("port latch", latch, 8'hF1);
        // Pins differ from the latch: clear and test must use the pins
        lvl <= 8'h0F;
        ex(14'h1085, 1);
        check("port pins", latch, 8'h0D);
        ex(14'h1885, 1);
        wr(REG_CTRL, 8'h01);
        wr(REG_ACC, 8'h33);
        ex(14'h0781, 1);
        check("timer", tcount, 8'h33);
        rd(REG_PRESC, 8'h01, "clears");
        ex(14'h0701, 1);
        wr(REG_CTRL, 8'h00);
        ex(14'h1781, 1);
        check("timer bit", tcount, 8'hB3);
        rd(REG_PRESC, 8'h01, "clears");
        // Reset in mid-run, during an execution cycle
        wr(REG_ACC, 8'h44);
        apb(1'b1, REG_INSN, 32'h3E01, 1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("reset outputs", {busy, pclr, latch, tcount}, 32'h0);
        rd(REG_ACC, 8'h00, "acc reset");
        rd(REG_PRESC, 8'h00, "clears reset");
        ex(14'h3E01, 1);
        rd(REG_ACC, 8'h01, "acc after reset");
        ex(14'h1C20, 1);
        rd(REG_ACC, 8'h01, "unsupported");
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge clk);
        check("run length", 1'b0, 1'b1);
        complete_run;
    end
endmodule : byte_bit_alu_instruction_exec_tb
